/* File: atg_pkg.sv */
// constants for the acquisition trigger, pacer and result fifo block
// assumes a 50 MHz system clock and an apb host with 32-bit data
package atg_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TB_HZ = 5_000_000;
  localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;
  localparam int unsigned TB_W = 4;
  // first conversion after a trigger, longest time, rounded down
  localparam int unsigned FIRST_NS = 400;
  localparam int unsigned FIRST_CYC = FIRST_NS * (CLK_HZ / 1_000_000) / 1000;
  // pacer start after the enabling write, longest time
  localparam int unsigned START_US = 1;
  localparam int unsigned START_CYC = START_US * (CLK_HZ / 1_000_000);
  // result fifo
  localparam int unsigned FIFO_DEPTH = 1024;
  localparam int unsigned FIFO_HALF = 512;
  localparam int unsigned DATA_W = 16;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SEL = 8'h04;
  localparam logic [7:0] A_DIV = 8'h08;
  localparam logic [7:0] A_COUNT = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_DATA = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  // control field positions
  localparam int unsigned C_EN = 0;
  localparam int unsigned C_TEXT = 1;
  localparam int unsigned C_MODE = 2;
  localparam int unsigned C_TRISE = 4;
  localparam int unsigned C_PEXT = 5;
  localparam int unsigned C_PRISE = 6;
  localparam int unsigned C_GEN = 7;
  localparam int unsigned C_GPOS = 8;
  localparam int unsigned C_DMA = 9;
  localparam int unsigned C_DUAL = 10;
  localparam int unsigned C_HF = 11;
  localparam int unsigned CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h000;
  // stop modes
  localparam logic [1:0] MODE_POST = 2'h0;
  localparam logic [1:0] MODE_PRE = 2'h1;
  localparam logic [1:0] MODE_ABOUT = 2'h2;
  // selection fields: interrupt line index, dma channel index
  localparam int unsigned S_IRQ = 0;
  localparam int unsigned S_DMA = 4;
  localparam logic [7:0] SEL_RST = 8'h00;
  // command bits
  localparam int unsigned K_STOP = 0;
  localparam int unsigned K_CLROVF = 1;
  // status positions
  localparam int unsigned T_OVF = 4;
  localparam int unsigned T_ALT = 5;
  localparam int unsigned T_FILL = 16;
  // other reset values
  localparam logic [31:0] DIV_RST = 32'h0002_0002;
  localparam logic [23:0] COUNT_RST = 24'h00_0400;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN = 4'h4,
    ST_TAIL = 4'h8
  } atg_state_e;
endpackage

/* File: atg_acq.sv */
// acquisition sequencer: triggers, pacer, gate, result fifo, dma and irq
// assumes an apb master, a converter on clk and host dma/irq logic outside
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - software start converts once operation is enabled
// - about trigger comes only from external input
// - trigger edge polarity chosen by software
// - internal pacer idle until trigger, fast start
// - external pacer: trigger arms, edges convert
// - pacer starts within 1 us after write
// - about trigger: stop after programmed samples
// - pre-trigger stops on the about event
// - pre and about modes need dma transfer
// - post mode stops on count or command
// - gate polarity selects allowed input level
// - gate only applies with internal pacer
// - gate off holds pacer, on reloads it
// - every result goes into 1024-word fifo until it is full
// - interrupt on not empty or half full
// - interrupt routed to one selected line
// - dma channel or pair chosen by software
// - fifo keeps storing while dma reprogrammed
// - pacer is two counters on 5 MHz base
module atg_acq #(
  parameter int unsigned DEPTH = atg_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_gate_input,
  input wire logic ext_pacer_input,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic [2:0] dma_req,
  input wire logic dma_ack,
  input wire logic dma_tc,
  output logic [15:0] dma_data,
  output logic [5:0] irq_line
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_V = (AW + 1)'(DEPTH);
  localparam logic [AW:0] HALF_V = (AW + 1)'(atg_pkg::FIFO_HALF);
  localparam logic [atg_pkg::TB_W-1:0] TB_LAST = atg_pkg::TB_W'(atg_pkg::TB_DIV - 1);

  // block state except the result storage in one record
  typedef struct packed {
    atg_pkg::atg_state_e st;
    logic [atg_pkg::CTRL_W-1:0] ctrl; // control word
    logic [7:0] sel; // irq line and dma channel choice
    logic [31:0] div; // pacer divisors, low and high counter
    logic [23:0] cnt; // programmed sample count
    logic [23:0] smp; // samples counted so far
    logic [15:0] c1; // first pacer counter
    logic [15:0] c2; // second pacer counter
    logic [atg_pkg::TB_W-1:0] tb; // time base divider
    logic [2:0] tsy; // trigger/gate synchroniser and history
    logic [2:0] psy; // external pacer synchroniser and history
    logic first; // first conversion pending
    logic gprev; // gate state last cycle
    logic conv; // conversion start pulse
    logic ovf; // sticky overflow
    logic alt; // second channel of a dual pair active
    logic dly; // fifo head not yet settled
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    logic [31:0] prdata;
    logic [15:0] dmad;
    logic [5:0] irq;
  } atg_regs_s;

  atg_regs_s q;
  atg_regs_s n;
  logic [15:0] mem [DEPTH]; // result storage
  logic trig_ev; // selected edge of the trigger input
  logic pac_ev; // selected edge of the external pacer
  logic gate_on; // conversions allowed by the gate
  logic gate_use; // gate in effect
  logic tick; // 5 MHz time base enable
  logic conv; // conversion request this cycle
  logic push;
  logic pop;
  logic pop_dma;
  logic ovf_ev;
  logic about_ok; // about trigger honoured
  logic counting; // samples being counted toward the stop
  logic go; // start write seen in idle
  logic stop; // software stop command
  logic clr; // overflow clear command
  logic arm; // trigger event taken, pacer loaded
  logic fin; // operation ends
  logic [1:0] mode;
  logic [1:0] ch; // active dma channel index
  logic [1:0] nx; // partner channel of a pair
  logic [31:0] rdv; // read mux value

  // one-hot decode, shared by dma request and irq routing
  function automatic logic [7:0] onehot(input logic [2:0] idx);
    onehot = 8'h01 << idx;
  endfunction

  // register map decode, used only by the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == atg_pkg::A_CTRL) || (a == atg_pkg::A_SEL) || (a == atg_pkg::A_DIV) ||
      (a == atg_pkg::A_COUNT) || (a == atg_pkg::A_STATUS) || (a == atg_pkg::A_DATA) ||
      (a == atg_pkg::A_CMD);
  endfunction

  // next-state logic for the whole block
  always_comb begin
    n = q;
    go = 1'b0;
    stop = 1'b0;
    clr = 1'b0;
    arm = 1'b0;
    fin = 1'b0;
    conv = 1'b0;
    rdv = 32'h0000_0000;
    // pins pass two flops; logic reads only the second and its history
    n.tsy = {q.tsy[1:0], trigger_gate_input};
    n.psy = {q.psy[1:0], ext_pacer_input};
    tick = (q.tb == TB_LAST);
    n.tb = tick ? '0 : q.tb + 1'b1;
    trig_ev = q.ctrl[atg_pkg::C_TRISE] ? (q.tsy[1] & ~q.tsy[2])
                                       : (~q.tsy[1] & q.tsy[2]);
    pac_ev = q.ctrl[atg_pkg::C_PRISE] ? (q.psy[1] & ~q.psy[2]) : (~q.psy[1] & q.psy[2]);
    // the shared input is a gate only against the internal pacer
    gate_use = q.ctrl[atg_pkg::C_GEN] & ~q.ctrl[atg_pkg::C_PEXT];
    gate_on = ~gate_use | (q.tsy[1] == q.ctrl[atg_pkg::C_GPOS]);
    mode = q.ctrl[atg_pkg::C_MODE +: 2];
    // pre and about stops fall back to post without dma
    about_ok = q.ctrl[atg_pkg::C_DMA] & (mode != atg_pkg::MODE_POST);
    counting = ((q.st == atg_pkg::ST_RUN) & ~about_ok) | (q.st == atg_pkg::ST_TAIL);

    // apb read capture in the setup cycle, so prdata comes from a flop
    case (paddr)
      atg_pkg::A_CTRL: rdv[atg_pkg::CTRL_W-1:0] = q.ctrl;
      atg_pkg::A_SEL: rdv[7:0] = q.sel;
      atg_pkg::A_DIV: rdv = q.div;
      atg_pkg::A_COUNT: rdv[23:0] = q.cnt;
      atg_pkg::A_STATUS: begin
        rdv[3:0] = q.st;
        rdv[atg_pkg::T_OVF] = q.ovf;
        rdv[atg_pkg::T_ALT] = q.alt;
        rdv[atg_pkg::T_FILL +: AW + 1] = q.fill;
      end
      atg_pkg::A_DATA: rdv[15:0] = mem[q.rp];
      default: rdv = 32'h0000_0000;
    endcase
    if (psel & ~penable & ~pwrite) begin
      n.prdata = rdv;
    end

    // apb writes take effect at the access edge
    if (psel & penable & pwrite) begin
      case (paddr)
        atg_pkg::A_CTRL: begin
          n.ctrl = pwdata[atg_pkg::CTRL_W-1:0];
          go = pwdata[atg_pkg::C_EN] & (q.st == atg_pkg::ST_IDLE);
        end
        atg_pkg::A_SEL: n.sel = pwdata[7:0];
        atg_pkg::A_DIV: n.div = pwdata;
        atg_pkg::A_COUNT: n.cnt = pwdata[23:0];
        atg_pkg::A_CMD: begin
          stop = pwdata[atg_pkg::K_STOP];
          clr = pwdata[atg_pkg::K_CLROVF];
        end
        default: ;
      endcase
    end

    // count results toward the programmed stop
    if (conv_done & counting) begin
      n.smp = q.smp + 24'h00_0001;
    end

    // sequencer
    unique case (q.st)
      atg_pkg::ST_IDLE: begin
        if (go) begin
          n.smp = '0;
          n.alt = 1'b0;
          if (pwdata[atg_pkg::C_TEXT]) begin
            n.st = atg_pkg::ST_WAIT;
          end else begin
            n.st = atg_pkg::ST_RUN;
            arm = 1'b1;
          end
        end
      end
      atg_pkg::ST_WAIT: begin
        // start on the selected trigger edge
        if (trig_ev) begin
          n.st = atg_pkg::ST_RUN;
          arm = 1'b1;
        end
      end
      atg_pkg::ST_RUN: begin
        // about event is only ever the external input edge
        if (about_ok & trig_ev) begin
          if (mode == atg_pkg::MODE_PRE) begin
            fin = 1'b1;
          end else begin
            n.st = atg_pkg::ST_TAIL;
            n.smp = '0;
          end
        end else if (counting & conv_done & (q.smp + 24'h00_0001 == q.cnt)) begin
          fin = 1'b1;
        end
      end
      atg_pkg::ST_TAIL: begin
        if (conv_done & (q.smp + 24'h00_0001 == q.cnt)) begin
          fin = 1'b1;
        end
      end
      default: n.st = atg_pkg::ST_IDLE;
    endcase

    // pacer: loaded at the trigger, counters idle before it
    if (arm) begin
      n.c1 = q.div[15:0];
      n.c2 = q.div[31:16];
      n.first = ~q.ctrl[atg_pkg::C_PEXT] | (go & ~pwdata[atg_pkg::C_PEXT]);
      if (go) begin
        n.first = ~pwdata[atg_pkg::C_PEXT];
      end
      n.gprev = 1'b1;
    end else if ((q.st == atg_pkg::ST_RUN) | (q.st == atg_pkg::ST_TAIL)) begin
      n.gprev = gate_on;
      if (q.ctrl[atg_pkg::C_PEXT]) begin
        conv = pac_ev;
      end else if (q.first) begin
        // a closed gate cancels the immediate start; the reopen paces instead
        conv = gate_on;
        n.first = 1'b0;
        // prescaler restarts so the next conversion is one whole period later
        n.tb = '0;
      end else if (gate_on & ~q.gprev) begin
        // gate reopened: restart the full period from the top
        n.c1 = q.div[15:0];
        n.c2 = q.div[31:16];
        n.tb = '0;
      end else if (gate_on & tick) begin
        // two cascaded counters; a closed gate simply holds them
        if (q.c1 <= 16'h0001) begin
          n.c1 = q.div[15:0];
          if (q.c2 <= 16'h0001) begin
            n.c2 = q.div[31:16];
            conv = 1'b1;
          end else begin
            n.c2 = q.c2 - 16'h0001;
          end
        end else begin
          n.c1 = q.c1 - 16'h0001;
        end
      end
    end

    // any stop returns to idle and drops the enable
    if (fin | stop) begin
      n.st = atg_pkg::ST_IDLE;
      n.ctrl[atg_pkg::C_EN] = 1'b0;
      n.first = 1'b0;
      conv = 1'b0;
    end
    n.conv = conv;

    // fifo: results are stored whatever the host is doing, except when the fifo is full
    push = conv_done & (q.fill != FULL_V);
    ovf_ev = conv_done & (q.fill == FULL_V);
    pop_dma = dma_ack & (q.fill != '0);
    pop = pop_dma | (psel & penable & ~pwrite & (paddr == atg_pkg::A_DATA) & (q.fill != '0));
    n.wp = q.wp + AW'(push);
    n.rp = q.rp + AW'(pop);
    n.fill = q.fill + (AW + 1)'(push) - (AW + 1)'(pop);
    // set beats clear in the same cycle
    n.ovf = (q.ovf & ~clr) | ovf_ev;
    // head register lags one cycle after any pop or a write into empty
    n.dmad = mem[q.rp];
    n.dly = pop | (q.fill == '0);

    // dual dma: switch to the partner channel at terminal count
    if (pop_dma & dma_tc & q.ctrl[atg_pkg::C_DUAL]) begin
      n.alt = ~q.alt;
    end

    // irq only when dma is not the transfer method
    if (~q.ctrl[atg_pkg::C_DMA] & (q.ctrl[atg_pkg::C_HF] ? (q.fill >= HALF_V)
                                                         : (q.fill != '0))) begin
      n.irq = 6'(onehot(q.sel[atg_pkg::S_IRQ +: 3]));
    end else begin
      n.irq = 6'h00;
    end
  end

  // pair partner: 0->1, 1->2, 2->0
  assign nx = (q.sel[atg_pkg::S_DMA +: 2] == 2'h2) ? 2'h0 : q.sel[atg_pkg::S_DMA +: 2] + 2'h1;
  assign ch = (q.ctrl[atg_pkg::C_DUAL] & q.alt) ? nx : q.sel[atg_pkg::S_DMA +: 2];
  // request held off while the head register settles
  assign dma_req = (q.ctrl[atg_pkg::C_DMA] & (q.fill != '0) & ~q.dly)
                   ? 3'(onehot({1'b0, ch})) : 3'h0;

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= atg_pkg::ST_IDLE;
      q.ctrl <= atg_pkg::CTRL_RST;
      q.sel <= atg_pkg::SEL_RST;
      q.div <= atg_pkg::DIV_RST;
      q.cnt <= atg_pkg::COUNT_RST;
      q.dly <= 1'b1;
      // synchronisers keep sampling so no false edge follows reset
      q.tsy <= n.tsy;
      q.psy <= n.psy;
    end else begin
      q <= n;
    end
  end

  // result storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp] <= conv_data;
    end
  end

  // outputs
  assign prdata = q.prdata;
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel & penable & ~mapped(paddr);
  assign conv_start = q.conv;
  assign dma_data = q.dmad;
  assign irq_line = q.irq;

  // checks
  localparam int FIRST_W = atg_pkg::FIRST_CYC;
  localparam int START_W = atg_pkg::START_CYC;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_first_conv: assert property (
    (q.st == atg_pkg::ST_WAIT) && trig_ev && !q.ctrl[atg_pkg::C_PEXT] && !stop && !gate_use
    |-> ##[1:FIRST_W] conv_start)
    else $error("first conversion late after trigger");
  a_sw_start: assert property (
    go && !pwdata[atg_pkg::C_TEXT] && !pwdata[atg_pkg::C_PEXT] && !pwdata[atg_pkg::C_GEN]
    |-> ##[1:START_W] conv_start)
    else $error("pacer not started after enabling write");
  a_sw_run: assert property (
    go && !pwdata[atg_pkg::C_TEXT] |=> q.st == atg_pkg::ST_RUN)
    else $error("software start did not run");
  a_trig_edge: assert property (
    (q.st == atg_pkg::ST_WAIT) && !stop && q.tsy[1] != q.tsy[2]
    && q.tsy[1] == q.ctrl[atg_pkg::C_TRISE] |=> q.st == atg_pkg::ST_RUN)
    else $error("selected trigger edge missed");
  a_ext_pace: assert property (
    q.ctrl[atg_pkg::C_PEXT] && $rose(conv_start) |-> $past(pac_ev))
    else $error("external pacer conversion without edge");
  a_gate_hold: assert property (
    gate_use && !gate_on && q.gprev == gate_on && !q.first && !arm |=> !conv_start)
    else $error("conversion while gate closed");
  a_pre_stop: assert property (
    (q.st == atg_pkg::ST_RUN) && about_ok && mode == atg_pkg::MODE_PRE && trig_ev
    |=> q.st == atg_pkg::ST_IDLE)
    else $error("pre-trigger did not stop on about event");
  a_no_tail: assert property (
    !q.ctrl[atg_pkg::C_DMA] && (q.st == atg_pkg::ST_RUN) |=> q.st != atg_pkg::ST_TAIL)
    else $error("about mode entered without dma");
  a_ovf_drop: assert property (
    conv_done && q.fill == FULL_V && !pop |=> q.ovf && q.fill == FULL_V)
    else $error("full fifo accepted a result");
  a_irq_ne: assert property (
    !q.ctrl[atg_pkg::C_DMA] && !q.ctrl[atg_pkg::C_HF] && q.fill != '0
    && q.sel[2:0] == 3'h0 && $stable(q.sel) |=> irq_line[0])
    else $error("not-empty interrupt missing");
  a_dma_swap: assert property (
    pop_dma && dma_tc && q.ctrl[atg_pkg::C_DUAL] |=> q.alt != $past(q.alt))
    else $error("dual dma did not switch channel");

  c_about_tail: cover property (
    (q.st == atg_pkg::ST_TAIL) ##[1:200] (q.st == atg_pkg::ST_IDLE));
  c_overflow: cover property (ovf_ev);
  c_gate_reopen: cover property (gate_use && gate_on && !q.gprev);
endmodule

`default_nettype wire

/* File: atg_host_model.sv */
// host side model: a converter answering conversion starts and a dma controller
// assumes one clock shared with the block; outputs change just after the rising edge
`timescale 1ns/1ps
`default_nettype none
module atg_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_start,
  output logic conv_done,
  output logic [15:0] conv_data,
  input wire logic [2:0] dma_req,
  output logic dma_ack,
  output logic dma_tc,
  input wire logic [15:0] dma_data,
  input wire logic dma_run,
  input wire logic [7:0] tc_len,
  output logic [15:0] acks,
  output logic [15:0] last_data,
  output logic [2:0] last_ch
);
  logic [2:0] busy_q; // conversion in flight, three cycles deep
  logic [15:0] seq_q; // value of the next result
  logic hold_q; // keeps acks at least three cycles apart
  logic take; // a request is seen and may be answered

  assign take = dma_run && !dma_ack && !hold_q && (dma_req != 3'h0);

  // converter: result three cycles after start; data toggles when not qualified
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 3'h0;
      seq_q <= 16'hA000;
      conv_done <= 1'b0;
      conv_data <= 16'h5FFF;
    end else begin
      busy_q <= {busy_q[1:0], conv_start};
      conv_done <= busy_q[1];
      if (busy_q[1]) begin
        conv_data <= seq_q;
        seq_q <= seq_q + 16'h0001;
      end else begin
        conv_data <= ~conv_data;
      end
    end
  end

  // dma controller: stalls while dma_run is low, terminal count every tc_len words
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_ack <= 1'b0;
      dma_tc <= 1'b0;
      hold_q <= 1'b0;
      acks <= 16'h0000;
      last_data <= 16'h0000;
      last_ch <= 3'h0;
    end else begin
      hold_q <= dma_ack;
      dma_ack <= take;
      // channel must be reprogrammed after tc_len transfers
      dma_tc <= take && (tc_len != 8'h00) && ((32'(acks) + 1) % 32'(tc_len) == 0);
      if (dma_ack) begin
        acks <= acks + 16'h0001;
        last_data <= dma_data;
        last_ch <= dma_req;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the acquisition sequencer over apb
// assumes atg_pkg and the host model; all waits are bounded
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic trigger_gate_input, ext_pacer_input, conv_start, conv_done, dma_ack, dma_tc;
  logic dma_run;
  logic [15:0] conv_data, dma_data, acks, last_data;
  logic [2:0] dma_req, last_ch;
  logic [5:0] irq_line;
  logic [7:0] tc_len;
  int fails, samples_checked, n_conv, c, n0;

  atg_acq i_atg_acq (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_gate_input(trigger_gate_input),
    .ext_pacer_input(ext_pacer_input), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .dma_req(dma_req), .dma_ack(dma_ack), .dma_tc(dma_tc),
    .dma_data(dma_data), .irq_line(irq_line));
  atg_host_model i_atg_host_model (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_tc(dma_tc), .dma_data(dma_data), .dma_run(dma_run), .tc_len(tc_len),
    .acks(acks), .last_data(last_data), .last_ch(last_ch));

  // 50 MHz clock
  always #10 clk = ~clk;

  // conversions started since the last reset
  always @(posedge clk) begin
    if (sys_rst) n_conv <= 0;
    else if (conv_start === 1'b1) n_conv <= n_conv + 1;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer; entered just after an edge, leaves one idle cycle behind it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin fails++; complete_run(); end
    rv = prdata; slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rv, e)
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // poll the state field until it shows st
  task automatic wait_state(input logic [3:0] st, input int bound);
    int n;
    n = 0;
    do begin apb(1'b0, atg_pkg::A_STATUS, 32'h0); n++; end while (rv[3:0] !== st && n < bound);
    `CHK(rv[3:0], st)
  endtask

  // cycles until a conversion start is seen, c returns the count
  task automatic wait_conv(input int bound, output int cc);
    cc = 0;
    while (conv_start !== 1'b1 && cc <= bound) begin @(posedge clk); cc++; end
    if (cc > bound) begin fails++; complete_run(); end
  endtask

  task automatic wait_nconv(input int t);
    int n;
    n = 0;
    while (n_conv < t && n < 20000) begin @(posedge clk); n++; end
    if (n_conv < t) begin fails++; complete_run(); end
  endtask

  task automatic wait_acks(input int t);
    int n;
    n = 0;
    while (acks < 16'(t) && n < 2000) begin @(posedge clk); n++; end
    if (acks < 16'(t)) begin fails++; complete_run(); end
  endtask

  task automatic rst();
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    trigger_gate_input = 0; ext_pacer_input = 0; dma_run = 1; tc_len = 8'h00;
    fails = 0; samples_checked = 0;
    rst();
    // reset values and an unmapped word
    rdchk(atg_pkg::A_CTRL, 32'h0);
    rdchk(atg_pkg::A_DIV, 32'h0002_0002);
    rdchk(atg_pkg::A_COUNT, 32'h400);
    rdchk(atg_pkg::A_STATUS, 32'h1);
    rdchk(8'h1C, 32'h0);
    `CHK(slv, 1'b1)
    $display("test reset done");
    // software start, post mode, dma stalled so the fifo must hold the data
    wr(atg_pkg::A_DIV, 32'h0002_0003); wr(atg_pkg::A_COUNT, 32'h5);
    dma_run <= 1'b0;
    wr(atg_pkg::A_CTRL, 32'h201);
    wait_conv(atg_pkg::START_CYC, c);
    @(posedge clk);
    wait_conv(100, c);
    `CHK(c + 1, 6 * atg_pkg::TB_DIV)
    wait_state(4'h1, 200);
    `CHK(n_conv, 5)
    rdchk(atg_pkg::A_CTRL, 32'h200);
    rdchk(atg_pkg::A_STATUS, 32'h0005_0001);
    dma_run <= 1'b1;
    wait_acks(5);
    `CHK(last_data, 16'hA004)
    $display("test post done");
    // every single channel and every dual pair; pairs get tc on the second word, single channels get none
    for (int d = 0; d < 2; d++) for (int i = 0; i < 3; i++) begin
      rst();
      tc_len <= 8'(2 * d);
      wr(atg_pkg::A_DIV, 32'h0001_0001); wr(atg_pkg::A_COUNT, 32'h3);
      wr(atg_pkg::A_SEL, 32'(i) << 4);
      wr(atg_pkg::A_CTRL, 32'h201 | (32'(d) << 10));
      wait_acks(3);
      `CHK(last_ch, (d == 1) ? 3'(1 << ((i + 1) % 3)) : 3'(1 << i))
      rdchk(atg_pkg::A_STATUS, 32'h1 | (32'(d) << 5));
    end
    $display("test dma done");
    // external trigger: the wrong edge is ignored, the right one starts
    for (int e = 0; e < 2; e++) begin
      trigger_gate_input <= e[0];
      rst();
      wr(atg_pkg::A_DIV, 32'h0001_0001); wr(atg_pkg::A_COUNT, 32'h1);
      wr(atg_pkg::A_CTRL, 32'h203 | (32'(e) << 4));
      rdchk(atg_pkg::A_STATUS, 32'h2);
      trigger_gate_input <= ~e[0];
      wait_cyc(30);
      `CHK(n_conv, 0)
      trigger_gate_input <= e[0];
      wait_conv(atg_pkg::FIRST_CYC, c);
    end
    $display("test trigger done");
    // external pacer with the gate bit set and the pin inhibiting: gate ignored
    trigger_gate_input <= 1'b0;
    rst();
    wr(atg_pkg::A_COUNT, 32'h0); wr(atg_pkg::A_CTRL, 32'h3E1);
    wait_cyc(40);
    `CHK(n_conv, 0)
    repeat (3) begin
      ext_pacer_input <= 1'b1; wait_cyc(10); ext_pacer_input <= 1'b0; wait_cyc(10);
    end
    `CHK(n_conv, 3)
    wr(atg_pkg::A_CMD, 32'h1);
    wait_state(4'h1, 20);
    $display("test pacer done");
    // gate of each polarity: blocked, reloaded on activation, held when off
    for (int p = 0; p < 2; p++) begin
      trigger_gate_input <= ~p[0];
      rst();
      wr(atg_pkg::A_DIV, 32'h0001_0001); wr(atg_pkg::A_COUNT, 32'h0);
      wr(atg_pkg::A_CTRL, 32'h281 | (32'(p) << 8));
      wait_cyc(40);
      `CHK(n_conv, 0)
      trigger_gate_input <= p[0];
      wait_conv(30, c);
      `CHK(c >= 10, 1'b1)
      trigger_gate_input <= ~p[0];
      wait_cyc(6); n0 = n_conv; wait_cyc(40);
      `CHK(n_conv, n0)
      wr(atg_pkg::A_CMD, 32'h1);
    end
    $display("test gate done");
    // pre-trigger stops on the event; about stops a count later
    trigger_gate_input <= 1'b0;
    rst();
    wr(atg_pkg::A_DIV, 32'h0001_0004); wr(atg_pkg::A_COUNT, 32'h0);
    wr(atg_pkg::A_CTRL, 32'h215);
    wait_nconv(2);
    trigger_gate_input <= 1'b1;
    wait_state(4'h1, 20);
    trigger_gate_input <= 1'b0;
    rst();
    wr(atg_pkg::A_DIV, 32'h0001_0004); wr(atg_pkg::A_COUNT, 32'h3);
    wr(atg_pkg::A_CTRL, 32'h219);
    wait_nconv(2); wait_cyc(10); n0 = n_conv;
    trigger_gate_input <= 1'b1;
    wait_state(4'h1, 200);
    `CHK(n_conv - n0, 3)
    // without dma the pre mode must not stop on the event
    trigger_gate_input <= 1'b0;
    rst();
    wr(atg_pkg::A_DIV, 32'h0001_0001); wr(atg_pkg::A_CTRL, 32'h015);
    wait_cyc(20); trigger_gate_input <= 1'b1; wait_cyc(40);
    apb(1'b0, atg_pkg::A_STATUS, 32'h0);
    `CHK(rv[3:0], 4'h4)
    wr(atg_pkg::A_CMD, 32'h1);
    $display("test stop modes done");
    // interrupt on every line when the fifo is not empty
    for (int i = 0; i < 6; i++) begin
      rst();
      wr(atg_pkg::A_SEL, 32'(i)); wr(atg_pkg::A_DIV, 32'h0001_0001);
      wr(atg_pkg::A_COUNT, 32'h1); wr(atg_pkg::A_CTRL, 32'h1);
      wait_state(4'h1, 20);
      `CHK(irq_line, 6'(1 << i))
      rdchk(atg_pkg::A_DATA, 32'hA000);
      wait_cyc(2);
      `CHK(irq_line, 6'h0)
    end
    // half-full interrupt, then overflow past the full depth
    rst();
    wr(atg_pkg::A_DIV, 32'h0001_0001); wr(atg_pkg::A_COUNT, 32'h0);
    wr(atg_pkg::A_CTRL, 32'h801);
    wait_nconv(511); wait_cyc(7);
    `CHK(irq_line, 6'h0)
    wait_nconv(512); wait_cyc(7);
    `CHK(irq_line, 6'h1)
    wait_nconv(1026); wait_cyc(7);
    wr(atg_pkg::A_CMD, 32'h1);
    rdchk(atg_pkg::A_STATUS, 32'h0400_0011);
    for (int k = 0; k < 1024; k++) rdchk(atg_pkg::A_DATA, 32'hA000 + 32'(k));
    rdchk(atg_pkg::A_STATUS, 32'h11);
    wr(atg_pkg::A_CMD, 32'h2);
    rdchk(atg_pkg::A_STATUS, 32'h1);
    $display("test fifo done");
    complete_run();
  end
endmodule
`default_nettype wire
